// [src/mci_bank.sv]
// Purpose: configuration, event flag and mask bank of a hardware monitor, indexed data port
// Assumes: host writes the index before data accesses; limit events come on this clock
// Notes: interrupt outputs are registered; data port answers one cycle after a read
`timescale 1ns/1ps
`include "mci_map.svh"
module mci_bank #(
	parameter int unsigned RST_PULSE_CYCLES = `MCI_RST_PULSE_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_addr_wr, // write pulse to the index port
	input wire logic i_data_wr, // write pulse to the data port
	input wire logic i_data_rd, // read pulse on the data port
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata, // data port contents
	output logic [6:0] o_index,
	input wire logic i_boot_code_wr, // self-test code write strobe
	input wire logic [7:0] i_boot_code_data,
	input wire logic i_meas_wr, // monitoring loop writes a reading
	input wire logic [4:0] i_meas_idx,
	input wire logic [7:0] i_meas_data,
	input wire logic i_limit_valid, // limit comparison result strobe
	input wire logic [7:0] i_limit_lo, // bits 0-4,6,7 used
	input wire logic [3:0] i_limit_hi, // voltage_ch4..neg_voltage_ch6, tach_ch3
	input wire logic i_board_temp_alert_in_n, // pin
	input wire logic i_chained_interrupt_in_n, // pin
	input wire logic i_intrusion_in, // pin, high on intrusion
	output logic o_monitor_run, // monitoring loop may run
	output logic o_mgmt_interrupt_out_n,
	output logic o_host_int_out, // high when NMI, low when IRQ active
	output logic o_sys_reset_n_o, // open-drain data, always low
	output logic o_sys_reset_n_oe, // high while driving low
	output logic o_bypass_n_o,
	output logic o_bypass_n_oe
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] cfg_reg; // config_control
	logic [7:0] flags_lo_reg; // event_flags_low
	logic [7:0] flags_hi_reg; // event_flags_high, bit 7 always zero
	logic [7:0] mgmt_mask_lo_reg;
	logic [7:0] mgmt_mask_hi_reg;
	logic [7:0] host_mask_lo_reg;
	logic [6:0] index_reg;
	logic [7:0] data_reg; // indexed_data_port
	logic [4:0] boot_ptr_reg; // separate pointer for code writes
	logic [7:0] log_mem [0:31];
	logic [7:0] meas_mem [0:31];
	logic [2:0] pins_sync; // synchronised pin levels
	logic access; // data port read or write
	logic soft_def; // soft defaults requested
	logic cfg_wr;
	logic frozen;
	logic mgmt_active;
	logic host_active;
	logic [7:0] flags_lo_next;
	logic [7:0] flags_hi_next;
	logic [7:0] set_lo;
	logic [7:0] set_hi;
	logic [7:0] sel_data;
	mci_pkg::mci_region_type rgn;
	mci_pulse_if pif ();
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// region of an index
	function automatic mci_pkg::mci_region_type region_of(input logic [6:0] idx);
		if (idx <= `MCI_IDX_LOG_TOP) begin
			region_of = mci_pkg::MCI_RGN_LOG;
		end else if (idx <= `MCI_IDX_MEAS_TOP) begin
			region_of = mci_pkg::MCI_RGN_MEAS;
		end else if (idx >= `MCI_IDX_ALIAS_BASE) begin
			region_of = mci_pkg::MCI_RGN_ALIAS;
		end else if (idx <= `MCI_IDX_HOST_MASK_LO) begin
			region_of = mci_pkg::MCI_RGN_REG;
		end else begin
			region_of = mci_pkg::MCI_RGN_NONE;
		end
	endfunction : region_of
	// index after a data access
	function automatic logic [6:0] next_index(input logic [6:0] idx);
		if (region_of(idx) == mci_pkg::MCI_RGN_LOG && idx != `MCI_IDX_LOG_TOP) begin
			next_index = idx + 7'h01;
		end else if (region_of(idx) == mci_pkg::MCI_RGN_ALIAS && idx != `MCI_IDX_ALIAS_TOP) begin
			next_index = idx + 7'h01;
		end else begin
			next_index = idx;
		end
	endfunction : next_index
	// ----------------------------------------
	// decode and pins
	// ----------------------------------------
	assign access = i_data_wr || i_data_rd;
	assign rgn = region_of(index_reg);
	assign cfg_wr = i_data_wr && index_reg == `MCI_IDX_CFG;
	assign soft_def = cfg_wr && i_wdata[`MCI_CFG_SOFT_DEFAULTS];
	assign frozen = cfg_reg[`MCI_CFG_FREEZE];
	// monitoring loop runs only when started and not frozen
	assign o_monitor_run = cfg_reg[`MCI_CFG_START] && !frozen;
	mci_sync #(
		.W(3),
		.INIT(3'h7) // idle level of every pin, so no false event follows reset
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_async({i_intrusion_in ? 1'b0 : 1'b1, i_chained_interrupt_in_n, i_board_temp_alert_in_n}),
		.o_sync(pins_sync)
	);
	// selected byte for a read
	always_comb begin
		sel_data = `MCI_ZERO_RESET;
		if (rgn == mci_pkg::MCI_RGN_LOG) begin
			sel_data = log_mem[index_reg[4:0]];
		end else if (rgn == mci_pkg::MCI_RGN_MEAS || rgn == mci_pkg::MCI_RGN_ALIAS) begin
			sel_data = meas_mem[index_reg[4:0]];
		end else if (index_reg == `MCI_IDX_CFG) begin
			sel_data = cfg_reg;
		end else if (index_reg == `MCI_IDX_FLAGS_LO) begin
			sel_data = flags_lo_reg;
		end else if (index_reg == `MCI_IDX_FLAGS_HI) begin
			sel_data = flags_hi_reg;
		end else if (index_reg == `MCI_IDX_MGMT_MASK_LO) begin
			sel_data = mgmt_mask_lo_reg;
		end else if (index_reg == `MCI_IDX_MGMT_MASK_HI) begin
			sel_data = mgmt_mask_hi_reg;
		end else if (index_reg == `MCI_IDX_HOST_MASK_LO) begin
			sel_data = host_mask_lo_reg;
		end
	end
	// ----------------------------------------
	// index and data port
	// ----------------------------------------
	// index written by host, advanced by data accesses in the log and alias regions
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			index_reg <= 7'h00;
		end else if (i_addr_wr) begin
			index_reg <= i_wdata[6:0];
		end else if (soft_def) begin
			index_reg <= 7'h00;
		end else if (access) begin
			index_reg <= next_index(index_reg);
		end
	end
	// data port latches what moved through it
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			data_reg <= `MCI_ZERO_RESET;
		end else if (soft_def) begin
			data_reg <= `MCI_ZERO_RESET;
		end else if (i_data_wr) begin
			data_reg <= i_wdata;
		end else if (i_data_rd) begin
			data_reg <= sel_data;
		end
	end
	assign o_rdata = data_reg;
	assign o_index = index_reg;
	// ----------------------------------------
	// log and measurement memories
	// ----------------------------------------
	// log memory: host writes and code writes
	always_ff @(posedge i_core_clk) begin
		if (i_data_wr && rgn == mci_pkg::MCI_RGN_LOG) begin
			log_mem[index_reg[4:0]] <= i_wdata;
		end else if (i_boot_code_wr) begin
			log_mem[boot_ptr_reg] <= i_boot_code_data;
		end
	end
	// code write pointer stops at the top
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			boot_ptr_reg <= 5'h00;
		end else if (soft_def) begin
			boot_ptr_reg <= 5'h00;
		end else if (i_boot_code_wr && boot_ptr_reg != 5'h1F) begin
			boot_ptr_reg <= boot_ptr_reg + 5'h01;
		end
	end
	// measurement memory: host writes win over the loop
	always_ff @(posedge i_core_clk) begin
		if (i_data_wr && (rgn == mci_pkg::MCI_RGN_MEAS || rgn == mci_pkg::MCI_RGN_ALIAS)) begin
			meas_mem[index_reg[4:0]] <= i_wdata;
		end else if (i_meas_wr && o_monitor_run) begin
			meas_mem[i_meas_idx] <= i_meas_data;
		end
	end
	// ----------------------------------------
	// configuration and masks
	// ----------------------------------------
	// configuration with self-clearing reset bit
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_reg <= `MCI_CFG_RESET;
		end else if (soft_def) begin
			cfg_reg <= `MCI_CFG_RESET;
		end else if (cfg_wr) begin
			cfg_reg <= i_wdata;
			// without the enable no pulse, bit does not stick
			if (!mgmt_mask_hi_reg[`MCI_MASK_HI_RST_EN]) begin
				cfg_reg[`MCI_CFG_RST_PULSE] <= 1'b0;
			end
		end else if (pif.done) begin
			cfg_reg[`MCI_CFG_RST_PULSE] <= 1'b0;
		end
	end
	assign pif.start = cfg_wr && !soft_def && i_wdata[`MCI_CFG_RST_PULSE]
		&& mgmt_mask_hi_reg[`MCI_MASK_HI_RST_EN];
	mci_pulse_timer #(
		.CYCLES(RST_PULSE_CYCLES)
	) u_timer (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.pif(pif)
	);
	// mask registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			mgmt_mask_lo_reg <= `MCI_ZERO_RESET;
			mgmt_mask_hi_reg <= `MCI_ZERO_RESET;
			host_mask_lo_reg <= `MCI_ZERO_RESET;
		end else if (soft_def) begin
			mgmt_mask_lo_reg <= `MCI_ZERO_RESET;
			mgmt_mask_hi_reg <= `MCI_ZERO_RESET;
			host_mask_lo_reg <= `MCI_ZERO_RESET;
		end else if (i_data_wr) begin
			if (index_reg == `MCI_IDX_MGMT_MASK_LO) begin
				mgmt_mask_lo_reg <= i_wdata;
			end else if (index_reg == `MCI_IDX_MGMT_MASK_HI) begin
				mgmt_mask_hi_reg <= i_wdata;
			end else if (index_reg == `MCI_IDX_HOST_MASK_LO) begin
				host_mask_lo_reg <= i_wdata;
			end
		end
	end
	// ----------------------------------------
	// event flags
	// ----------------------------------------
	// new events; none recorded while frozen
	always_comb begin
		set_lo = 8'h00;
		set_hi = 8'h00;
		if (!frozen) begin
			if (i_limit_valid && o_monitor_run) begin
				set_lo = i_limit_lo & 8'hDF;
				set_hi[3:0] = i_limit_hi;
			end
			set_lo[5] = !pins_sync[0];
			set_hi[4] = !pins_sync[2];
			set_hi[6] = !pins_sync[1];
			set_hi[`MCI_FLAGS_HI_OVERFLOW] = i_boot_code_wr && boot_ptr_reg == 5'h1F;
		end
	end
	// clear on read, set wins; of all writes only soft defaults reach the flags
	always_comb begin
		flags_lo_next = flags_lo_reg;
		flags_hi_next = flags_hi_reg;
		if (i_data_rd && !i_data_wr && index_reg == `MCI_IDX_FLAGS_LO) begin
			flags_lo_next = 8'h00;
		end
		if (i_data_rd && !i_data_wr && index_reg == `MCI_IDX_FLAGS_HI) begin
			flags_hi_next = 8'h00;
		end
		flags_lo_next = flags_lo_next | set_lo;
		flags_hi_next = (flags_hi_next | set_hi) & 8'h7F;
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			flags_lo_reg <= `MCI_ZERO_RESET;
			flags_hi_reg <= `MCI_ZERO_RESET;
		end else if (soft_def) begin
			flags_lo_reg <= `MCI_ZERO_RESET;
			flags_hi_reg <= `MCI_ZERO_RESET;
		end else begin
			flags_lo_reg <= flags_lo_next;
			flags_hi_reg <= flags_hi_next;
		end
	end
	// ----------------------------------------
	// output lines
	// ----------------------------------------
	// start bit takes no part, so clearing it keeps lines up
	assign mgmt_active = ((|(flags_lo_reg & ~mgmt_mask_lo_reg))
		|| (|(flags_hi_reg[6:0] & ~mgmt_mask_hi_reg[6:0])))
		&& cfg_reg[`MCI_CFG_MGMT_EN] && !frozen;
	assign host_active = (|(flags_lo_reg & ~host_mask_lo_reg))
		&& cfg_reg[`MCI_CFG_HOST_EN] && !frozen;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mgmt_interrupt_out_n <= 1'b1;
			o_host_int_out <= 1'b1;
			o_bypass_n_oe <= 1'b0;
		end else begin
			o_mgmt_interrupt_out_n <= !mgmt_active;
			// NMI style drives high when active, IRQ style low
			o_host_int_out <= cfg_reg[`MCI_CFG_NMI_SEL] ? host_active : !host_active;
			o_bypass_n_oe <= cfg_reg[`MCI_CFG_BYPASS];
		end
	end
	assign o_bypass_n_o = 1'b0;
	assign o_sys_reset_n_o = 1'b0;
	assign o_sys_reset_n_oe = pif.active;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence log_top_access_s;
		access && !i_addr_wr && !soft_def && index_reg == `MCI_IDX_LOG_TOP;
	endsequence
	sequence rst_nomask_wr_s;
		cfg_wr && !soft_def && i_wdata[`MCI_CFG_RST_PULSE]
			&& !mgmt_mask_hi_reg[`MCI_MASK_HI_RST_EN] && !pif.active;
	endsequence
	log_stop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		log_top_access_s |=> index_reg == `MCI_IDX_LOG_TOP)
		else $error("log index moved past top");
	alias_incr_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		access && !i_addr_wr && !soft_def && index_reg >= `MCI_IDX_ALIAS_BASE
		&& index_reg != `MCI_IDX_ALIAS_TOP |=> index_reg == $past(index_reg) + 7'h01)
		else $error("alias index did not advance");
	data_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_data_wr && !soft_def |=> o_rdata == $past(i_wdata))
		else $error("data port lost write");
	mgmt_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!cfg_reg[`MCI_CFG_MGMT_EN] |=> o_mgmt_interrupt_out_n)
		else $error("management line asserted while disabled");
	freeze_lines_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		frozen |=> o_mgmt_interrupt_out_n
		&& o_host_int_out == !$past(cfg_reg[`MCI_CFG_NMI_SEL]))
		else $error("line active while frozen");
	freeze_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		frozen && !i_data_rd && !soft_def |=> $stable(flags_lo_reg) && $stable(flags_hi_reg))
		else $error("flags changed while frozen");
	rst_enable_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rst_nomask_wr_s |=> !o_sys_reset_n_oe [*2])
		else $error("reset pulse without enable");
	soft_def_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		soft_def |=> cfg_reg == `MCI_CFG_RESET && flags_lo_reg == 8'h00
		&& mgmt_mask_hi_reg == 8'h00)
		else $error("soft defaults incomplete");
	clear_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_data_rd && !i_data_wr && !soft_def && index_reg == `MCI_IDX_FLAGS_LO
		|=> flags_lo_reg == $past(set_lo) && o_rdata == $past(flags_lo_reg))
		else $error("status read did not return and clear");
	host_line_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cfg_reg[`MCI_CFG_HOST_EN] && !frozen && (|(flags_lo_reg & ~host_mask_lo_reg))
		|=> o_host_int_out == $past(cfg_reg[`MCI_CFG_NMI_SEL]))
		else $error("host line missed unmasked flag");
endmodule : mci_bank

// [src/mci_map.svh]
// Purpose: offsets, field positions, reset values and timing of the monitor register bank
// Assumes: 7-bit index, 8-bit data port
// Notes: definitions only
`ifndef MCI_MAP_SVH
`define MCI_MAP_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define MCI_IDX_CFG 7'h40
`define MCI_IDX_FLAGS_LO 7'h41
`define MCI_IDX_FLAGS_HI 7'h42
`define MCI_IDX_MGMT_MASK_LO 7'h43
`define MCI_IDX_MGMT_MASK_HI 7'h44
`define MCI_IDX_HOST_MASK_LO 7'h45
`define MCI_IDX_LOG_TOP 7'h1F
`define MCI_IDX_MEAS_BASE 7'h20
`define MCI_IDX_MEAS_TOP 7'h3F
`define MCI_IDX_ALIAS_BASE 7'h60
`define MCI_IDX_ALIAS_TOP 7'h7F
// ----------------------------------------
// configuration fields
// ----------------------------------------
`define MCI_CFG_START 0
`define MCI_CFG_MGMT_EN 1
`define MCI_CFG_HOST_EN 2
`define MCI_CFG_FREEZE 3
`define MCI_CFG_RST_PULSE 4
`define MCI_CFG_NMI_SEL 5
`define MCI_CFG_BYPASS 6
`define MCI_CFG_SOFT_DEFAULTS 7
`define MCI_MASK_HI_RST_EN 7
`define MCI_FLAGS_HI_OVERFLOW 5
// ----------------------------------------
// reset values
// ----------------------------------------
`define MCI_CFG_RESET 8'h08
`define MCI_ZERO_RESET 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define MCI_CLK_MHZ 125
`define MCI_RST_PULSE_MS 20
`define MCI_RST_PULSE_CYCLES (`MCI_RST_PULSE_MS * `MCI_CLK_MHZ * 1000)
`endif

// [src/mci_pkg.sv]
// Purpose: types shared by the monitor register bank
// Assumes: nothing
// Notes: constants live in mci_map.svh
package mci_pkg;
	// index region of the data port
	typedef enum logic [2:0] {
		MCI_RGN_LOG = 3'h0,
		MCI_RGN_MEAS = 3'h1,
		MCI_RGN_ALIAS = 3'h2,
		MCI_RGN_REG = 3'h3,
		MCI_RGN_NONE = 3'h4
	} mci_region_type;
	// reset pulse timer states
	typedef enum logic [0:0] {
		MCI_TMR_IDLE = 1'h0,
		MCI_TMR_PULSE = 1'h1
	} mci_tmr_state_type;
endpackage : mci_pkg

// [src/mci_pulse_if.sv]
// Purpose: request and status between the bank and its pulse timer
// Assumes: one clock
// Notes: start and done are one-cycle pulses
`timescale 1ns/1ps
interface mci_pulse_if;
	logic start; // one-cycle request
	logic active; // level while the pulse runs
	logic done; // one-cycle pulse at the end
	modport ctrl (output start, input active, input done);
	modport timer (input start, output active, output done);
endinterface : mci_pulse_if

// [src/mci_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: pins are asynchronous to i_core_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module mci_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_reg; // first stage, read by second only
	// ----------------------------------------
	// two stages
	// ----------------------------------------
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= INIT;
			o_sync <= INIT;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule : mci_sync

// [src/mci_pulse_timer.sv]
// Purpose: fixed-length low pulse for the reset output
// Assumes: start only while idle matters
// Notes: a start during a pulse is ignored
`timescale 1ns/1ps
module mci_pulse_timer #(
	parameter int unsigned CYCLES = 32'd2500000
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	mci_pulse_if.timer pif
);
	mci_pkg::mci_tmr_state_type state_reg;
	logic [31:0] cnt_reg; // cycles spent in the pulse
	// ----------------------------------------
	// pulse sequencing
	// ----------------------------------------
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= mci_pkg::MCI_TMR_IDLE;
			cnt_reg <= 32'h0;
		end else begin
			case (state_reg)
				mci_pkg::MCI_TMR_IDLE: begin
					cnt_reg <= 32'h0;
					if (pif.start) begin
						state_reg <= mci_pkg::MCI_TMR_PULSE;
					end
				end
				mci_pkg::MCI_TMR_PULSE: begin
					// hold at least the full count before releasing
					if (cnt_reg == CYCLES - 32'd1) begin
						state_reg <= mci_pkg::MCI_TMR_IDLE;
					end
					cnt_reg <= cnt_reg + 32'd1;
				end
				default: begin
					state_reg <= mci_pkg::MCI_TMR_IDLE;
				end
			endcase
		end
	end
	assign pif.active = (state_reg == mci_pkg::MCI_TMR_PULSE);
	assign pif.done = pif.active && (cnt_reg == CYCLES - 32'd1);
	// pulse never ends short of the count
	pulse_len_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(pif.active) |-> $past(cnt_reg) == CYCLES - 32'd1)
		else $error("reset pulse ended early");
endmodule : mci_pulse_timer

// [bench/mci_host_model.sv]
// Purpose: host processor model on the index and data ports
// Assumes: strobes launched 1 ns after a rising edge, held one cycle
// Notes: released write data is inverted so stale values cannot match
`timescale 1ns/1ps
module mci_host_model (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output logic o_addr_wr,
	output logic o_data_wr,
	output logic o_data_rd,
	output logic [7:0] o_wdata
);
	// ----------------------------------------
	// idle bus at time zero
	// ----------------------------------------
	initial begin
		o_addr_wr = 1'b0;
		o_data_wr = 1'b0;
		o_data_rd = 1'b0;
		o_wdata = 8'h5A;
	end
	// index write, made before each run of data accesses
	task automatic set_index(input logic [6:0] idx);
		@(posedge i_core_clk);
		#1;
		o_addr_wr = 1'b1;
		o_wdata = {1'b0, idx};
		@(posedge i_core_clk);
		#1;
		o_addr_wr = 1'b0;
		o_wdata = ~o_wdata;
	endtask : set_index
	// one data port write
	task automatic put_data(input logic [7:0] d);
		@(posedge i_core_clk);
		#1;
		o_data_wr = 1'b1;
		o_wdata = d;
		@(posedge i_core_clk);
		#1;
		o_data_wr = 1'b0;
		o_wdata = ~d;
	endtask : put_data
	// one data port read, result taken after the answering edge
	task automatic get_data(output logic [7:0] d);
		@(posedge i_core_clk);
		#1;
		o_data_rd = 1'b1;
		@(posedge i_core_clk);
		#1;
		o_data_rd = 1'b0;
		d = i_rdata;
	endtask : get_data
endmodule : mci_host_model

// [bench/tb_monitor_config_irq_regs.sv]
// Purpose: self-checking bench of the monitor register bank
// Assumes: reset pulse shortened to 8 cycles
// Notes: host accesses go through the host model
`timescale 1ns/1ps
module tb_monitor_config_irq_regs;
	logic i_core_clk = 1'b0, i_rst = 1'b1, i_boot_code_wr = 1'b0, i_limit_valid = 1'b0;
	logic i_board_temp_alert_in_n = 1'b1, i_chained_interrupt_in_n = 1'b1, i_intrusion_in = 1'b0;
	logic [7:0] i_boot_code_data = 8'h00, i_limit_lo = 8'h00, o_rdata, i_wdata;
	logic [3:0] i_limit_hi = 4'h0;
	logic i_meas_wr = 1'b0;
	logic [4:0] i_meas_idx = 5'h00;
	logic [7:0] i_meas_data = 8'h00;
	logic [6:0] o_index;
	logic i_addr_wr, i_data_wr, i_data_rd, o_monitor_run, o_mgmt_interrupt_out_n, o_host_int_out;
	logic o_sys_reset_n_o, o_sys_reset_n_oe, o_bypass_n_o, o_bypass_n_oe;
	int mismatches = 0;
	int compares = 0;
	// ----------------------------------------
	// clock, host and device
	// ----------------------------------------
	always #4 i_core_clk = ~i_core_clk;
	mci_host_model host (.i_core_clk, .i_rdata(o_rdata), .o_addr_wr(i_addr_wr),
		.o_data_wr(i_data_wr), .o_data_rd(i_data_rd), .o_wdata(i_wdata));
	mci_bank #(.RST_PULSE_CYCLES(8)) dut (.i_core_clk, .i_rst, .i_addr_wr, .i_data_wr,
		.i_data_rd, .i_wdata, .o_rdata, .o_index, .i_boot_code_wr, .i_boot_code_data,
		.i_meas_wr, .i_meas_idx, .i_meas_data, .i_limit_valid,
		.i_limit_lo, .i_limit_hi, .i_board_temp_alert_in_n, .i_chained_interrupt_in_n,
		.i_intrusion_in, .o_monitor_run, .o_mgmt_interrupt_out_n, .o_host_int_out,
		.o_sys_reset_n_o, .o_sys_reset_n_oe, .o_bypass_n_o, .o_bypass_n_oe);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		host.set_index(idx);
		host.put_data(d);
	endtask : wr
	task automatic rd(input logic [6:0] idx, input logic [7:0] exp, input string what);
		logic [7:0] v;
		host.set_index(idx);
		host.get_data(v);
		chk(what, exp, v);
	endtask : rd
	// limit strobe, pins held active for a few cycles
	task automatic ev(input logic [7:0] lo, input logic [3:0] hi, input logic pins);
		tick(1);
		i_limit_valid = 1'b1;
		i_limit_lo = lo;
		i_limit_hi = hi;
		{i_board_temp_alert_in_n, i_chained_interrupt_in_n, i_intrusion_in} = {~pins, ~pins, pins};
		tick(1);
		i_limit_valid = 1'b0;
		i_limit_lo = ~lo;
		tick(4);
		{i_board_temp_alert_in_n, i_chained_interrupt_in_n, i_intrusion_in} = 3'b110;
		tick(5);
	endtask : ev
	// one monitoring loop write into the measurement memory
	task automatic meas(input logic [4:0] idx, input logic [7:0] d);
		tick(1);
		i_meas_wr = 1'b1;
		i_meas_idx = idx;
		i_meas_data = d;
		tick(1);
		i_meas_wr = 1'b0;
	endtask : meas
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_values;
		chk("data port", 8'h00, o_rdata);
		chk("run", 8'h00, {7'h00, o_monitor_run});
		chk("lines", 8'h03, {6'h00, o_mgmt_interrupt_out_n, o_host_int_out});
		rd(7'h40, 8'h08, "config");
		rd(7'h43, 8'h00, "mgmt mask lo");
		rd(7'h44, 8'h00, "mgmt mask hi");
		rd(7'h45, 8'h00, "host mask");
	endtask : t_reset_values
	task automatic t_auto_increment;
		wr(7'h1E, 8'h11);
		host.put_data(8'h22);
		chk("log index", 8'h1F, {1'b0, o_index});
		rd(7'h1E, 8'h11, "log 1E");
		host.get_data(i_boot_code_data);
		chk("log 1F", 8'h22, i_boot_code_data);
		wr(7'h7E, 8'h33);
		host.put_data(8'h44);
		chk("alias index", 8'h7F, {1'b0, o_index});
		rd(7'h3E, 8'h33, "meas 3E");
		rd(7'h3F, 8'h44, "meas 3F");
	endtask : t_auto_increment
	task automatic t_flags;
		wr(7'h40, 8'h01);
		chk("run", 8'h01, {7'h00, o_monitor_run});
		meas(5'h05, 8'h77);
		rd(7'h25, 8'h77, "meas loop write");
		wr(7'h41, 8'hFF);
		rd(7'h41, 8'h00, "flags lo");
		ev(8'hDF, 4'hF, 1'b1);
		chk("lines off", 8'h03, {6'h00, o_mgmt_interrupt_out_n, o_host_int_out});
		rd(7'h41, 8'hFF, "flags lo");
		rd(7'h42, 8'h5F, "flags hi");
		rd(7'h41, 8'h00, "flags lo");
	endtask : t_flags
	task automatic t_lines;
		wr(7'h40, 8'h07);
		ev(8'h01, 4'h0, 1'b0);
		chk("lines on", 8'h00, {6'h00, o_mgmt_interrupt_out_n, o_host_int_out});
		wr(7'h40, 8'h27);
		tick(2);
		chk("nmi style", 8'h01, {7'h00, o_host_int_out});
		wr(7'h40, 8'h26);
		tick(2);
		chk("start off", 8'h01, {6'h00, o_mgmt_interrupt_out_n, o_host_int_out});
		wr(7'h43, 8'h01);
		wr(7'h45, 8'h01);
		tick(2);
		chk("masked", 8'h02, {6'h00, o_mgmt_interrupt_out_n, o_host_int_out});
		rd(7'h41, 8'h01, "masked flag");
		wr(7'h43, 8'h00);
		wr(7'h45, 8'h00);
		wr(7'h40, 8'h07);
		ev(8'h01, 4'h0, 1'b0);
		wr(7'h40, 8'h0F);
		ev(8'h02, 4'h0, 1'b0);
		chk("frozen", 8'h03, {6'h00, o_mgmt_interrupt_out_n, o_host_int_out});
		chk("run", 8'h00, {7'h00, o_monitor_run});
		rd(7'h41, 8'h01, "frozen flag");
	endtask : t_lines
	task automatic t_reset_pulse;
		int n;
		n = 0;
		wr(7'h40, 8'h10);
		tick(3);
		chk("no pulse", 8'h00, {7'h00, o_sys_reset_n_oe});
		rd(7'h40, 8'h00, "config");
		wr(7'h44, 8'h80);
		wr(7'h40, 8'h10);
		for (int c = 0; c < 40; c++) begin
			if (o_sys_reset_n_oe === 1'b1)
				n++;
			tick(1);
		end
		chk("pulse cycles", 8'h08, n[7:0]);
		chk("pin low", 8'h00, {7'h00, o_sys_reset_n_o});
		rd(7'h40, 8'h00, "config");
	endtask : t_reset_pulse
	task automatic t_bypass_defaults;
		wr(7'h40, 8'h40);
		tick(2);
		chk("bypass", 8'h02, {6'h00, o_bypass_n_oe, o_bypass_n_o});
		wr(7'h43, 8'h5A);
		wr(7'h40, 8'h80);
		tick(2);
		chk("bypass", 8'h00, {7'h00, o_bypass_n_oe});
		rd(7'h40, 8'h08, "config");
		rd(7'h43, 8'h00, "mgmt mask lo");
		rd(7'h44, 8'h00, "mgmt mask hi");
	endtask : t_bypass_defaults
	task automatic t_overflow;
		wr(7'h40, 8'h00);
		meas(5'h05, 8'h99);
		rd(7'h25, 8'h77, "meas standby write");
		for (int i = 0; i < 32; i++) begin
			tick(1);
			i_boot_code_wr = 1'b1;
			i_boot_code_data = 8'hC0 + i[7:0];
			tick(1);
			i_boot_code_wr = 1'b0;
			if (i == 30)
				rd(7'h42, 8'h00, "before overflow");
		end
		rd(7'h42, 8'h20, "overflow");
		rd(7'h00, 8'hC0, "log 00");
	endtask : t_overflow
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(20);
		i_rst = 1'b0;
		t_reset_values();
		t_auto_increment();
		t_flags();
		t_lines();
		t_reset_pulse();
		t_bypass_defaults();
		t_overflow();
		tally_and_finish();
	end
endmodule : tb_monitor_config_irq_regs
